// [src/fvs_seq.sv]
// Flash command sequencer: erase verify of a block or a section, read of the
// reserved once field and phrase program, launched from an indexed parameter set.
// Assumes one clock, a synchronous array port and an AXI4-Lite master.
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns

module fvs_seq
	import fvs_pkg::*;
#(
	parameter int          ADDR_W    = 8,
	parameter logic [17:0] BLK_WORDS = 18'h08000,
	parameter logic [3:0]  BLK_VALID = 4'b1001,
	parameter logic [3:0]  BLK_PFL   = 4'b1000
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   arr_req,
	output logic                   arr_we,
	output logic                   arr_info,
	output logic [16:0]            arr_addr,
	output logic [15:0]            arr_wdata,
	input  wire logic              arr_ack,
	input  wire logic [15:0]       arr_rdata,
	input  wire logic              arr_err,
	input  wire logic              arr_fatal,
	output logic                   pflash_rd_invalid
);

	typedef struct packed {
		fvs_state_e      st;
		logic            ccf;
		logic            acc;
		logic            pv;
		logic            ve;
		logic            vu;
		logic [2:0]      idx;
		logic            ext_en;
		logic [18:0]     prot;
		logic [5:0][15:0] prm;
		logic [7:0]      cmd;
		logic            info;
		logic [16:0]     waddr;
		logic [17:0]     left;
		logic [1:0]      wsel;
		logic            ro_busy;
	} fvs_seq_s;

	fvs_seq_s q;
	fvs_seq_s d;

	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_ok;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0]       rd_data;
	logic              rd_ok;
	logic              go;
	logic              go_we;
	logic [15:0]       go_wdata;
	logic              a_done;
	logic [15:0]       a_rdata;
	logic              a_err;
	logic              a_fatal;
	logic              launch;
	logic              bad;
	logic              prot_hit;
	logic [19:0]       last_b;
	logic [2:0]        wix;

	// Byte-lane merge of a 16-bit field.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb);
		merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	// Word-aligned address match against a register offset.
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus slave and array port.
	fvs_axil #(.ADDR_W(ADDR_W)) u_axil (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_ok         (wr_ok),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok)
	);

	fvs_arr u_arr (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.go         (go),
		.go_we      (go_we),
		.go_info    (d.info),
		.go_addr    (d.waddr),
		.go_wdata   (go_wdata),
		.arr_req    (arr_req),
		.arr_we     (arr_we),
		.arr_info   (arr_info),
		.arr_addr   (arr_addr),
		.arr_wdata  (arr_wdata),
		.arr_ack    (arr_ack),
		.arr_rdata  (arr_rdata),
		.arr_err    (arr_err),
		.arr_fatal  (arr_fatal),
		.done       (a_done),
		.done_rdata (a_rdata),
		.done_err   (a_err),
		.done_fatal (a_fatal)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register decode for writes and reads; unmapped addresses answer with an error.
	assign wr_ok = hit(wr_addr, OFS_STATUS) || hit(wr_addr, OFS_INDEX) ||
		hit(wr_addr, OFS_PARAM) || hit(wr_addr, OFS_CTRL) || hit(wr_addr, OFS_PROT);
	assign rd_ok = hit(rd_addr, OFS_STATUS) || hit(rd_addr, OFS_INDEX) ||
		hit(rd_addr, OFS_PARAM) || hit(rd_addr, OFS_CTRL) || hit(rd_addr, OFS_PROT);

	always_comb begin
		rd_data = 32'h00000000;
		if (hit(rd_addr, OFS_STATUS)) begin
			rd_data[STAT_CCF] = q.ccf;
			rd_data[STAT_ACC] = q.acc;
			rd_data[STAT_PV]  = q.pv;
			rd_data[STAT_VE]  = q.ve;
			rd_data[STAT_VU]  = q.vu;
		end else if (hit(rd_addr, OFS_INDEX)) begin
			rd_data[2:0] = q.idx;
		end else if (hit(rd_addr, OFS_PARAM)) begin
			rd_data[15:0] = (q.idx < IX_COUNT) ? q.prm[q.idx] : 16'h0000;
		end else if (hit(rd_addr, OFS_CTRL)) begin
			rd_data[0] = q.ext_en;
		end else if (hit(rd_addr, OFS_PROT)) begin
			rd_data[18:0] = q.prot;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Launch checks on the loaded parameter set.
	assign launch = wr_en && hit(wr_addr, OFS_STATUS) && wr_strb[0] && wr_data[STAT_CCF] &&
		q.ccf && q.st == ST_IDLE && !q.acc && !q.pv;
	assign last_b = {2'b00, q.prm[0][1:0], q.prm[1]} + {1'b0, q.prm[2], 3'b000} - 20'h00008;
	assign prot_hit = ({1'b0, q.prm[0][1:0], q.prm[1]} >= q.prot);

	always_comb begin
		case (q.prm[0][15:8])
			CMD_EV_BLK: begin
				bad = (q.idx != IX_EV_BLK) || !BLK_VALID[q.prm[0][1:0]];
			end
			CMD_EV_SEC: begin
				bad = (q.idx != IX_EV_SEC) || !q.ext_en ||
					!BLK_PFL[q.prm[0][1:0]] ||
					(q.prm[1][2:0] != 3'b000) ||
					((q.prm[2] != 16'h0000) && (last_b[19:17] != {2'b00, q.prm[0][1]}));
			end
			CMD_RD_ONCE: begin
				bad = (q.idx != IX_RD_ONCE) || !q.ext_en || (q.prm[1] > RO_LAST_INDEX);
			end
			CMD_PROG: begin
				bad = (q.idx != IX_PROG) || !q.ext_en || !BLK_PFL[q.prm[0][1:0]] ||
					(q.prm[1][2:0] != 3'b000);
			end
			default: begin
				bad = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state: register writes, launch, and the word-by-word array walk.
	assign wix      = IX_WORD0 + {1'b0, q.wsel};
	assign go_we    = (d.st == ST_WR);
	assign go_wdata = q.prm[IX_WORD0 + {1'b0, d.wsel}];
	assign pflash_rd_invalid = q.ro_busy;

	always_comb begin
		d  = q;
		go = 1'b0;
		if (wr_en) begin
			if (hit(wr_addr, OFS_STATUS) && wr_strb[0]) begin
				if (wr_data[STAT_ACC]) begin
					d.acc = 1'b0;
				end
				if (wr_data[STAT_PV]) begin
					d.pv = 1'b0;
				end
			end
			if (q.ccf && hit(wr_addr, OFS_INDEX) && wr_strb[0]) begin
				d.idx = wr_data[2:0];
			end
			if (q.ccf && hit(wr_addr, OFS_PARAM) && q.idx < IX_COUNT) begin
				d.prm[q.idx] = merge16(q.prm[q.idx], wr_data[15:0], wr_strb[1:0]);
			end
			if (q.ccf && hit(wr_addr, OFS_CTRL) && wr_strb[0]) begin
				d.ext_en = wr_data[0];
			end
			if (q.ccf && hit(wr_addr, OFS_PROT)) begin
				d.prot = wr_data[18:0];
			end
		end
		// A refused command never starts, so the complete flag stays set.
		if (launch) begin
			d.cmd  = q.prm[0][15:8];
			d.wsel = 2'b00;
			d.info = 1'b0;
			if (bad) begin
				d.acc = 1'b1;
			end else if (q.prm[0][15:8] == CMD_PROG && prot_hit) begin
				d.pv = 1'b1;
			end else begin
				d.ccf = 1'b0;
				d.ve  = 1'b0;
				d.vu  = 1'b0;
				go    = 1'b1;
				d.st  = ST_RD;
				case (q.prm[0][15:8])
					CMD_EV_BLK: begin
						d.waddr = {q.prm[0][1:0], 15'h0000};
						d.left  = BLK_WORDS;
					end
					CMD_EV_SEC: begin
						d.waddr = {q.prm[0][1:0], q.prm[1][15:1]};
						d.left  = {q.prm[2], 2'b00};
						if (q.prm[2] == 16'h0000) begin
							d.ccf = 1'b1;
							go    = 1'b0;
							d.st  = ST_IDLE;
						end
					end
					CMD_RD_ONCE: begin
						d.waddr   = {12'h000, q.prm[1][2:0], 2'b00};
						d.info    = 1'b1;
						d.left    = PHRASE_WORDS;
						d.ro_busy = 1'b1;
					end
					default: begin
						d.waddr = {q.prm[0][1:0], q.prm[1][15:1]};
						d.left  = PHRASE_WORDS;
						d.st    = ST_WR;
					end
				endcase
			end
		end
		case (q.st)
			ST_IDLE: begin
			end
			ST_WR: begin
				// Four writes, then back to the first word for the read-back.
				if (a_done) begin
					d.ve = q.ve | a_err;
					d.vu = q.vu | a_fatal;
					go   = 1'b1;
					if (q.wsel == 2'b11) begin
						d.st    = ST_RD;
						d.waddr = q.waddr - 17'h00003;
						d.wsel  = 2'b00;
						d.left  = PHRASE_WORDS;
					end else begin
						d.waddr = q.waddr + 17'h00001;
						d.wsel  = q.wsel + 2'b01;
					end
				end
			end
			ST_RD: begin
				// Protect violation is never raised here; only the verify flags move, plus the complete flag on the last word.
				if (a_done) begin
					d.vu = q.vu | a_fatal;
					d.ve = q.ve | a_err;
					if ((q.cmd == CMD_EV_BLK || q.cmd == CMD_EV_SEC) && a_rdata != ERASED_WORD) begin
						d.ve = 1'b1;
					end
					if (q.cmd == CMD_PROG && a_rdata != q.prm[wix]) begin
						d.ve = 1'b1;
					end
					if (q.cmd == CMD_RD_ONCE) begin
						d.prm[wix] = a_rdata;
					end
					d.waddr = q.waddr + 17'h00001;
					d.wsel  = q.wsel + 2'b01;
					d.left  = q.left - 18'h00001;
					if (q.left == 18'h00001) begin
						d.st      = ST_IDLE;
						d.ccf     = 1'b1;
						d.ro_busy = 1'b0;
						d.info    = 1'b0;
					end else begin
						go = 1'b1;
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
	end

	// State register; the complete flag comes out of reset set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q        <= '0;
			q.st     <= ST_IDLE;
			q.ccf    <= 1'b1;
			q.ext_en <= RST_EXT_EN;
			q.prot   <= RST_PROT;
		end else begin
			q <= d;
		end
	end

endmodule

// [include/fvs_pkg.sv]
// Shared constants for the flash command sequencer: register map, status bit
// positions, command codes, parameter indexes and reset values.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit flash array word.
package fvs_pkg;

	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_INDEX  = 8'h04;
	localparam logic [7:0] OFS_PARAM  = 8'h08;
	localparam logic [7:0] OFS_CTRL   = 8'h0C;
	localparam logic [7:0] OFS_PROT   = 8'h10;

	// Bit positions inside flash_status_reg.
	localparam int STAT_CCF = 7;
	localparam int STAT_ACC = 5;
	localparam int STAT_PV  = 4;
	localparam int STAT_VE  = 1;
	localparam int STAT_VU  = 0;

	// Command codes carried in the upper byte of parameter word 0.
	localparam logic [7:0] CMD_EV_BLK  = 8'h02;
	localparam logic [7:0] CMD_EV_SEC  = 8'h03;
	localparam logic [7:0] CMD_RD_ONCE = 8'h04;
	localparam logic [7:0] CMD_PROG    = 8'h06;

	// Parameter index that each command expects at launch, the index of the first phrase word, and the index count.
	localparam logic [2:0] IX_EV_BLK  = 3'h0;
	localparam logic [2:0] IX_RD_ONCE = 3'h1;
	localparam logic [2:0] IX_EV_SEC  = 3'h2;
	localparam logic [2:0] IX_PROG    = 3'h5;
	localparam logic [2:0] IX_WORD0   = 3'h2;
	localparam logic [2:0] IX_COUNT   = 3'h6;

	// Array and field constants.
	localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
	localparam logic [15:0] RO_LAST_INDEX = 16'h0007;
	localparam logic [17:0] PHRASE_WORDS  = 18'h00004;

	// Values after reset, and the AXI4-Lite response codes.
	localparam logic        RST_EXT_EN = 1'b1;
	localparam logic [18:0] RST_PROT   = 19'h40000;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;

	// Sequencer states, one-hot.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WR   = 3'b010,
		ST_RD   = 3'b100
	} fvs_state_e;

endpackage

// [src/fvs_axil.sv]
// AXI4-Lite slave front end for the flash command sequencer.
// Assumes the register decode next door answers combinationally on rd_addr.
`timescale 1ns/1ns
module fvs_axil
	import fvs_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   wr_en,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_ok,
	output logic [ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_ok
);

	typedef struct packed {
		logic              aw_v;
		logic              w_v;
		logic [ADDR_W-1:0] awa;
		logic [31:0]       wd;
		logic [3:0]        ws;
		logic              bv;
		logic [1:0]        br;
		logic              ar_v;
		logic [ADDR_W-1:0] ara;
		logic              rv;
		logic [31:0]       rd;
		logic [1:0]        rr;
	} fvs_axil_s;

	fvs_axil_s q;
	fvs_axil_s d;

	////////////////////////////////////////////////////////////////////////////
	// Handshakes; address and data are taken in either order, one at a time.
	assign s_axi_awready = !q.aw_v && !q.bv;
	assign s_axi_wready  = !q.w_v && !q.bv;
	assign s_axi_arready = !q.ar_v && !q.rv;
	assign s_axi_bvalid  = q.bv;
	assign s_axi_bresp   = q.br;
	assign s_axi_rvalid  = q.rv;
	assign s_axi_rdata   = q.rd;
	assign s_axi_rresp   = q.rr;
	assign wr_en         = q.aw_v && q.w_v && !q.bv;
	assign wr_addr       = q.awa;
	assign wr_data       = q.wd;
	assign wr_strb       = q.ws;
	assign rd_addr       = q.ara;

	// Next state of the slave; the write lands on the edge that raises bvalid.
	always_comb begin
		d = q;
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_v = 1'b1;
			d.awa  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_v = 1'b1;
			d.wd  = s_axi_wdata;
			d.ws  = s_axi_wstrb;
		end
		if (wr_en) begin
			d.aw_v = 1'b0;
			d.w_v  = 1'b0;
			d.bv   = 1'b1;
			d.br   = wr_ok ? RESP_OKAY : RESP_SLV;
		end else if (q.bv && s_axi_bready) begin
			d.bv = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			d.ar_v = 1'b1;
			d.ara  = s_axi_araddr;
		end
		if (q.ar_v) begin
			d.ar_v = 1'b0;
			d.rv   = 1'b1;
			d.rd   = rd_data;
			d.rr   = rd_ok ? RESP_OKAY : RESP_SLV;
		end else if (q.rv && s_axi_rready) begin
			d.rv = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// [src/fvs_arr.sv]
// Flash array access port: one word read or write per request.
// Assumes the array raises arr_ack for one cycle while arr_req is high.
`timescale 1ns/1ns
module fvs_arr
	import fvs_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        go,
	input  wire logic        go_we,
	input  wire logic        go_info,
	input  wire logic [16:0] go_addr,
	input  wire logic [15:0] go_wdata,
	output logic             arr_req,
	output logic             arr_we,
	output logic             arr_info,
	output logic [16:0]      arr_addr,
	output logic [15:0]      arr_wdata,
	input  wire logic        arr_ack,
	input  wire logic [15:0] arr_rdata,
	input  wire logic        arr_err,
	input  wire logic        arr_fatal,
	output logic             done,
	output logic [15:0]      done_rdata,
	output logic             done_err,
	output logic             done_fatal
);

	typedef struct packed {
		logic        req;
		logic        we;
		logic        info;
		logic [16:0] addr;
		logic [15:0] wdata;
		logic        done;
		logic [15:0] rdata;
		logic        err;
		logic        fatal;
	} fvs_arr_s;

	fvs_arr_s q;
	fvs_arr_s d;

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register.
	assign arr_req    = q.req;
	assign arr_we     = q.we;
	assign arr_info   = q.info;
	assign arr_addr   = q.addr;
	assign arr_wdata  = q.wdata;
	assign done       = q.done;
	assign done_rdata = q.rdata;
	assign done_err   = q.err;
	assign done_fatal = q.fatal;

	// Request held until acknowledged; the result is latched for the sequencer.
	always_comb begin
		d      = q;
		d.done = 1'b0;
		if (q.req && arr_ack) begin
			d.req   = 1'b0;
			d.done  = 1'b1;
			d.rdata = arr_rdata;
			d.err   = arr_err;
			d.fatal = arr_fatal;
		end else if (go && !q.req) begin
			d.req   = 1'b1;
			d.we    = go_we;
			d.info  = go_info;
			d.addr  = go_addr;
			d.wdata = go_wdata;
		end
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// [verif/fvs_seq_props.sv]
// Port assertions for the flash command sequencer.
// Assumes a bind onto fvs_seq, one clock and a sync active-low reset.
`timescale 1ns/1ns
module fvs_props (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic        arr_req,
	input logic        arr_ack,
	input logic        arr_info,
	input logic [16:0] arr_addr,
	input logic        pflash_rd_invalid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	// Handshake steps that start the bus answers.
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rtake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_req_hold;
		arr_req && !arr_ack |=> arr_req && $stable(arr_addr);
	endproperty
	property p_req_gap;
		arr_req && arr_ack |=> !arr_req;
	endproperty
	property p_inv;
		arr_req && arr_info |-> pflash_rd_invalid;
	endproperty
	property p_rng;
		arr_req && arr_info |-> arr_addr < 17'h00020;
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_wr_lat;
		s_wtake |-> ##2 s_axi_bvalid;
	endproperty
	property p_rd_lat;
		s_rtake |-> ##2 s_axi_rvalid;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("array request moved");
	a_req_gap: assert property (p_req_gap) else $error("request not dropped");
	a_inv: assert property (p_inv) else $error("flash reads not flagged invalid");
	a_rng: assert property (p_rng) else $error("reserved address out of field");
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
endmodule

bind fvs_seq fvs_props u_props (.*);

// [verif/fvs_seq_tb.sv]
// Register-level bench for the flash command sequencer.
// Assumes a small word store answering the array port in one cycle.
`timescale 1ns/1ns
module fvs_seq_tb import fvs_pkg::*;;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, v;
	logic        arr_req, arr_we, arr_info, pflash_rd_invalid;
	logic [16:0] arr_addr;
	logic [15:0] arr_wdata;
	logic        arr_ack = 1'h0;
	logic        arr_err = 1'h0;
	logic        arr_fatal = 1'h0;
	logic [15:0] arr_rdata = 16'h0;
	logic        bad = 1'h0;
	logic        erri = 1'h0;
	logic        fati = 1'h0;
	logic        seen = 1'h0;
	logic [15:0] mem [16];
	int          failures = 0;
	int          samples_checked = 0;

	always #10 aclk = ~aclk;
	// A short block keeps whole-block verifies brief.
	fvs_seq #(.BLK_WORDS(18'h00010)) uut (.*);
	////////////////////////////////////////////////////////////////////////
	// Array stand-in; bad inverts read data so a read-back can mismatch.
	always @(posedge aclk) begin
		arr_ack <= arr_req && !arr_ack;
		arr_err <= erri;
		arr_fatal <= fati;
		arr_rdata <= arr_info ? {4'hC, arr_addr[11:0]} : mem[arr_addr[3:0]] ^ {16{bad}};
		if (arr_req && arr_we && !arr_ack) mem[arr_addr[3:0]] <= arr_wdata;
		if (pflash_rd_invalid) seen <= 1'h1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Ready is sampled at the falling edge; it only moves on rising edges.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ha, hw, hb;
		pa = 1'h1;
		pw = 1'h1;
		hb = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!hb) begin
			@(negedge aclk);
			ha = pa && s_axi_awready;
			hw = pw && s_axi_wready;
			hb = !pa && !pw && s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'h0;
			if (hw) s_axi_wvalid <= 1'h0;
			pa = pa && !ha;
			pw = pw && !hw;
		end
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic pa, ha, hr;
		pa = 1'h1;
		hr = 1'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!hr) begin
			@(negedge aclk);
			ha = pa && s_axi_arready;
			hr = !pa && s_axi_rvalid;
			d = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ha) s_axi_arvalid <= 1'h0;
			pa = pa && !ha;
		end
		s_axi_rready <= 1'h0;
	endtask
	task automatic ld(input logic [2:0] i, input logic [15:0] w);
		wr(OFS_INDEX, {29'h0, i});
		wr(OFS_PARAM, {16'h0, w});
	endtask
	// Launch at index i, wait for completion, compare masked status, clear the access and protect-violation flags.
	task automatic go(input logic [2:0] i, input logic [7:0] m, input logic [7:0] e);
		int n;
		n = 0;
		wr(OFS_INDEX, {29'h0, i});
		wr(OFS_STATUS, 32'h00000080);
		rd(OFS_STATUS, v);
		while (v[STAT_CCF] !== 1'h1 && n < 300) begin
			rd(OFS_STATUS, v);
			n++;
		end
		cmp(v & {24'h0, m}, {24'h0, e});
		wr(OFS_STATUS, 32'h00000030);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#1500000;
		failures++;
		close_out();
	end
	initial begin
		for (int k = 0; k < 16; k++) mem[k] = ERASED_WORD;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		rd(OFS_STATUS, v);
		cmp(v, 32'h00000080);
		rd(8'h40, v);
		cmp({30'h0, rsp}, {30'h0, RESP_SLV});
		wr(8'h40, 32'h0);
		cmp({30'h0, rsp}, {30'h0, RESP_SLV});
		wr(OFS_CTRL, 32'h1);
		cmp({30'h0, rsp}, {30'h0, RESP_OKAY});
		ld(0, 16'h0200);
		go(0, 8'hFF, 8'h80);
		ld(0, 16'h0201);
		go(0, 8'hFF, 8'hA0);
		ld(0, 16'h0203);
		go(1, 8'hFF, 8'hA0);
		go(0, 8'hFF, 8'h80);
		ld(0, 16'h0303);
		ld(1, 16'h0000);
		ld(2, 16'h0002);
		go(2, 8'hFF, 8'h80);
		go(1, 8'hFF, 8'hA0);
		ld(1, 16'h0004);
		go(2, 8'hFF, 8'hA0);
		ld(1, 16'hFFF8);
		go(2, 8'hFF, 8'hA0);
		ld(1, 16'h0000);
		ld(0, 16'h0300);
		go(2, 8'hFF, 8'hA0);
		ld(0, 16'h0303);
		wr(OFS_CTRL, 32'h0);
		go(2, 8'hFF, 8'hA0);
		wr(OFS_CTRL, 32'h1);
		ld(0, 16'h0400);
		ld(1, 16'h0003);
		go(1, 8'hFF, 8'h80);
		cmp({31'h0, seen}, 32'h1);
		cmp({31'h0, pflash_rd_invalid}, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_INDEX, 32'(2 + k));
			rd(OFS_PARAM, v);
			cmp(v, 32'h0000C00C + 32'(k));
		end
		ld(1, 16'h0008);
		go(1, 8'hFF, 8'hA0);
		ld(1, 16'h0003);
		erri <= 1'h1;
		fati <= 1'h1;
		go(1, 8'hFF, 8'h83);
		erri <= 1'h0;
		fati <= 1'h0;
		ld(0, 16'h0603);
		ld(1, 16'h0008);
		for (int k = 0; k < 4; k++) ld(3'(2 + k), 16'h5A00 + 16'(k));
		go(5, 8'hFF, 8'h80);
		for (int k = 0; k < 4; k++) cmp({16'h0, mem[4 + k]}, 32'h5A00 + 32'(k));
		go(4, 8'hFF, 8'hA0);
		ld(1, 16'h0009);
		go(5, 8'hFF, 8'hA0);
		ld(1, 16'h0018);
		wr(OFS_PROT, 32'h00030000);
		go(5, 8'hFF, 8'h90);
		wr(OFS_PROT, 32'h00040000);
		bad <= 1'h1;
		ld(1, 16'h0010);
		go(5, 8'h02, 8'h02);
		bad <= 1'h0;
		close_out();
	end
endmodule
